//--- rtl/fdiop_pkg.sv
`default_nettype none
package fdiop_pkg;
  // ==========================================================
  // bus widths
  localparam int unsigned FDIOP_AW = 16;
  localparam int unsigned FDIOP_DW = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [15:0] FDIOP_CTRL_OFS = 16'h0000;
  localparam logic [15:0] FDIOP_STEP_OFS = 16'h0004;
  localparam logic [15:0] FDIOP_FAULT_OFS = 16'h0008;
  localparam logic [15:0] FDIOP_SNSEL_OFS = 16'h000C;
  localparam logic [15:0] FDIOP_SNAP_OFS = 16'h0010;
  localparam logic [15:0] FDIOP_CMD_OFS = 16'h0014;
  localparam logic [15:0] FDIOP_DATA_OFS = 16'h0018;
  localparam logic [15:0] FDIOP_STAT_OFS = 16'h001C;

  // ==========================================================
  // control, fault, command and status field positions
  localparam int unsigned FDIOP_CTRL_ARM = 0;
  localparam int unsigned FDIOP_CTRL_PH_LO = 1;
  localparam int unsigned FDIOP_CTRL_STEP = 4;
  localparam int unsigned FDIOP_CTRL_TM_LO = 5;
  localparam int unsigned FDIOP_CTRL_RESUME = 7;
  localparam int unsigned FDIOP_FLT_DEV = 0;
  localparam int unsigned FDIOP_FLT_MEM = 1;
  localparam int unsigned FDIOP_CMD_WRITE = 0;
  localparam int unsigned FDIOP_ST_DONE = 5;
  localparam int unsigned FDIOP_ST_ERR = 6;

  // ==========================================================
  // test modes, snapshot groups and deskew stage count
  localparam logic [1:0] FDIOP_TM_OFF = 2'h0;
  localparam logic [1:0] FDIOP_TM_SHORT = 2'h1;
  localparam logic [1:0] FDIOP_TM_LONG = 2'h2;
  localparam logic [2:0] FDIOP_SNAP_GROUPS = 3'h7;
  localparam int unsigned FDIOP_DESKEW_STAGES = 2;

  // ==========================================================
  // reset values
  localparam logic [31:0] FDIOP_WORD_RST = 32'h0000_0000;
  localparam logic [2:0] FDIOP_PH_RST = 3'h0;

  typedef enum logic [2:0] {
    PH_IDLE, PH_FETCH, PH_BUFIN, PH_DESKEW, PH_STOR, PH_BUFOUT, PH_STORE
  } fdiop_phase_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] data;
  } fdiop_stor_req_s;
endpackage
`default_nettype wire

//--- rtl/fdiop_deskew.sv
`default_nettype none
module fdiop_deskew import fdiop_pkg::*; #(
  parameter int unsigned STAGES = FDIOP_DESKEW_STAGES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // stream in, advanced only while en is high
  input wire logic en,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  // realigned stream out
  output logic out_valid,
  output logic [31:0] out_data
);
  typedef struct packed {
    logic [STAGES-1:0] vld;
    logic [STAGES-1:0][31:0] dat;
  } fdiop_dsk_s;

  fdiop_dsk_s st_reg, st_next;

  // ==========================================================
  // lane realignment pipeline; frozen with the sequencer so a halt
  // never lets a word slip through unseen
  always_comb begin
    st_next = st_reg;
    if (en) begin
      st_next.vld[0] = in_valid;
      st_next.dat[0] = in_data;
      for (int i = 1; i < STAGES; i++) begin
        st_next.vld[i] = st_reg.vld[i-1];
        st_next.dat[i] = st_reg.dat[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.vld[STAGES-1];
  assign out_data = st_reg.dat[STAGES-1];
endmodule
`default_nettype wire

//--- rtl/fdiop_maint.sv
// Operation
// - armed phase is stored; sequencer halts on entering that phase, except fetch, which a command enters from idle
// - after such a halt all sequencer state stays frozen for snapshot reads
// - snapshot read returns one of seven selectable internal groups
// - step mode advances the sequencer at most one phase per step write; the storage and deskew phases take more than one step
// - injected device or memory faults act exactly like real ones
// - two test modes answer normal commands while storage is simulated
// - short loop: memory to buffer and back to memory
// - long loop: memory, buffer, deskew logic, buffer, memory
// - maintenance commands are special writes and reads on the direct bus
// - each transfer carries a 32-bit word and a 16-bit address
//
// Our own choices: the Wishbone interface to the registers and the address map.
`default_nettype none
module fdiop_maint import fdiop_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // wishbone slave, the direct_io_bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  // storage unit link
  output fdiop_stor_req_s stor_o,
  input wire logic stor_ack_i,
  input wire logic [31:0] stor_rdata_i,
  // fault pins
  input wire logic dev_fault_i,
  input wire logic mem_fault_i
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic halt_arm;
    logic [2:0] halt_ph;
    logic step_mode;
    logic [1:0] tmode;
    logic inj_dev;
    logic inj_mem;
    logic [2:0] snap_sel;
    logic [31:0] mem_word;
    logic [31:0] buf_word;
    logic [31:0] result;
    fdiop_stor_req_s stor;
    logic dir;
    fdiop_phase_e phase;
    logic halted;
    logic done;
    logic error;
    logic dev_seen;
    logic mem_seen;
    logic [15:0] op_count;
    logic [1:0] dev_sync;
    logic [1:0] mem_sync;
    logic [1:0] ack_sync;
    logic [31:0] rd_s1;
    logic [31:0] rd_s2;
  } fdiop_state_s;

  fdiop_state_s st_reg, st_next;
  logic acc, wr, ctrl_wr, step_wr, adv, busy, fault_any, dsk_in, dsk_valid;
  logic [31:0] dsk_data;

  // ==========================================================
  // helpers
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [2:0] ph_code(input fdiop_phase_e p);
    return p;
  endfunction

  function automatic logic [31:0] status_word(input fdiop_state_s s);
    return {21'h0, s.tmode, s.mem_seen, s.dev_seen, s.error, s.done,
            (s.phase != PH_IDLE), s.halted, ph_code(s.phase)};
  endfunction

  // ==========================================================
  // bus decode: answer one cycle after the request, writes commit at
  // the edge where the master samples ack, so data is stable then
  assign acc = cyc_i && stb_i && !st_reg.ack;
  assign wr = cyc_i && stb_i && we_i && st_reg.ack;
  assign ctrl_wr = wr && (adr_i == FDIOP_CTRL_OFS);
  assign step_wr = wr && (adr_i == FDIOP_STEP_OFS);
  assign busy = (st_reg.phase != PH_IDLE);
  assign fault_any = st_reg.inj_dev || st_reg.inj_mem ||
                     st_reg.dev_sync[1] || st_reg.mem_sync[1];
  assign adv = !st_reg.halted && (!st_reg.step_mode || step_wr);
  assign dsk_in = adv && (st_reg.phase == PH_BUFIN) && (st_reg.tmode == FDIOP_TM_LONG);

  fdiop_deskew #(
    .STAGES(FDIOP_DESKEW_STAGES)
  ) u_deskew (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .en(adv),
    .in_valid(dsk_in),
    .in_data(st_reg.buf_word),
    .out_valid(dsk_valid),
    .out_data(dsk_data)
  );

  always_comb begin
    logic [31:0] rd;
    logic [31:0] cw;
    rd = 32'h0000_0000;
    cw = wmerge(32'h0000_0000, dat_i, sel_i);
    st_next = st_reg;
    // ========================================================
    // pin synchronisers
    st_next.dev_sync = {st_reg.dev_sync[0], dev_fault_i};
    st_next.mem_sync = {st_reg.mem_sync[0], mem_fault_i};
    st_next.ack_sync = {st_reg.ack_sync[0], stor_ack_i};
    st_next.rd_s1 = stor_rdata_i;
    st_next.rd_s2 = st_reg.rd_s1;
    // ========================================================
    // read mux
    unique case (adr_i)
      FDIOP_CTRL_OFS: rd = {24'h0, 1'b0, st_reg.tmode, st_reg.step_mode,
                           st_reg.halt_ph, st_reg.halt_arm};
      FDIOP_FAULT_OFS: rd = {30'h0, st_reg.inj_mem, st_reg.inj_dev};
      FDIOP_SNSEL_OFS: rd = {29'h0, st_reg.snap_sel};
      FDIOP_SNAP_OFS: begin
        unique case (st_reg.snap_sel)
          3'h0: rd = status_word(st_reg);
          3'h1: rd = st_reg.buf_word;
          3'h2: rd = dsk_data;
          3'h3: rd = st_reg.result;
          3'h4: rd = st_reg.mem_word;
          3'h5: rd = {28'h0, st_reg.stor.valid, st_reg.stor.write,
                      st_reg.mem_sync[1], st_reg.dev_sync[1]};
          3'h6: rd = {st_reg.op_count, 15'h0, st_reg.dir};
          default: rd = 32'h0000_0000;
        endcase
      end
      FDIOP_DATA_OFS: rd = st_reg.mem_word;
      FDIOP_STAT_OFS: rd = status_word(st_reg);
      default: rd = 32'h0000_0000;
    endcase
    st_next.ack = acc;
    if (acc) st_next.dat = rd;
    // ========================================================
    // maintenance writes
    if (ctrl_wr) begin
      if (sel_i[0]) begin
        st_next.halt_arm = cw[FDIOP_CTRL_ARM];
        st_next.halt_ph = cw[FDIOP_CTRL_PH_LO +: 3];
        st_next.step_mode = cw[FDIOP_CTRL_STEP];
        st_next.tmode = cw[FDIOP_CTRL_TM_LO +: 2];
        if (cw[FDIOP_CTRL_RESUME] || !cw[FDIOP_CTRL_ARM]) st_next.halted = 1'b0;
      end
    end
    if (wr && adr_i == FDIOP_FAULT_OFS && sel_i[0]) begin
      st_next.inj_dev = cw[FDIOP_FLT_DEV];
      st_next.inj_mem = cw[FDIOP_FLT_MEM];
    end
    if (wr && adr_i == FDIOP_SNSEL_OFS && sel_i[0]) st_next.snap_sel = cw[2:0];
    if (wr && adr_i == FDIOP_DATA_OFS && !busy) begin
      st_next.mem_word = wmerge(st_reg.mem_word, dat_i, sel_i);
    end
    if (wr && adr_i == FDIOP_STAT_OFS && sel_i[0]) begin
      if (cw[FDIOP_ST_DONE]) st_next.done = 1'b0;
      if (cw[FDIOP_ST_ERR]) st_next.error = 1'b0;
    end
    if (wr && adr_i == FDIOP_CMD_OFS && !busy) begin
      st_next.dir = cw[FDIOP_CMD_WRITE];
      st_next.phase = PH_FETCH;
      st_next.op_count = st_reg.op_count + 16'h0001;
    end
    if (st_reg.dev_sync[1] || st_reg.inj_dev) st_next.dev_seen = 1'b1;
    if (st_reg.mem_sync[1] || st_reg.inj_mem) st_next.mem_seen = 1'b1;
    // ========================================================
    // phase sequencer
    if (adv && busy) begin
      if (fault_any) begin
        st_next.phase = PH_IDLE;
        st_next.error = 1'b1;
        st_next.stor.valid = 1'b0;
      end else begin
        unique case (st_reg.phase)
          PH_FETCH: begin
            st_next.buf_word = st_reg.mem_word;
            st_next.phase = PH_BUFIN;
          end
          PH_BUFIN: begin
            if (st_reg.tmode == FDIOP_TM_SHORT) begin
              st_next.phase = PH_BUFOUT;
            end else if (st_reg.tmode == FDIOP_TM_LONG) begin
              st_next.phase = PH_DESKEW;
            end else begin
              st_next.phase = PH_STOR;
            end
          end
          PH_DESKEW: begin
            if (dsk_valid) begin
              st_next.buf_word = dsk_data;
              st_next.phase = PH_BUFOUT;
            end
          end
          PH_STOR: begin
            // handshake with the storage unit; ack is a synced level
            st_next.stor = '{valid: 1'b1, write: st_reg.dir, data: st_reg.buf_word};
            if (st_reg.ack_sync[1] && st_reg.stor.valid) begin
              st_next.stor.valid = 1'b0;
              if (!st_reg.dir) st_next.buf_word = st_reg.rd_s2;
              st_next.phase = PH_BUFOUT;
            end
          end
          PH_BUFOUT: begin
            st_next.result = st_reg.buf_word;
            st_next.phase = PH_STORE;
          end
          PH_STORE: begin
            st_next.mem_word = st_reg.result;
            st_next.done = 1'b1;
            st_next.phase = PH_IDLE;
          end
          default: st_next.phase = PH_IDLE;
        endcase
      end
      // halt on entry into the armed phase; set beats a resume clear
      if (st_reg.halt_arm && st_next.phase != st_reg.phase &&
          ph_code(st_next.phase) == st_reg.halt_ph) begin
        st_next.halted = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{phase: PH_IDLE, halt_ph: FDIOP_PH_RST, dat: FDIOP_WORD_RST,
                  mem_word: FDIOP_WORD_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ack_o = st_reg.ack;
  assign dat_o = st_reg.dat;
  assign stor_o = st_reg.stor;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_bufin_short;
    adv && !fault_any && st_reg.phase == PH_BUFIN && st_reg.tmode == FDIOP_TM_SHORT;
  endsequence
  sequence s_short_tail;
    st_reg.phase == PH_BUFOUT ##1 st_reg.phase == PH_STORE;
  endsequence

  property p_ack_pulse;
    st_reg.ack |=> !st_reg.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");

  property p_ack_answer;
    cyc_i && stb_i && !st_reg.ack |=> st_reg.ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  property p_halt_enter;
    st_reg.halt_arm && !st_reg.halted && adv && busy && !fault_any &&
    st_next.phase != st_reg.phase && ph_code(st_next.phase) == st_reg.halt_ph
    |=> st_reg.halted;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("armed phase not halted");

  property p_halt_freeze;
    st_reg.halted && !wr |=> $stable(st_reg.phase) && $stable(st_reg.buf_word);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("state moved while halted");

  property p_step_hold;
    st_reg.step_mode && !wr |=> $stable(st_reg.phase);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("phase moved without a step");

  property p_snap_range;
    acc && adr_i == FDIOP_SNAP_OFS && st_reg.snap_sel >= FDIOP_SNAP_GROUPS
    |=> st_reg.dat == 32'h0000_0000;
  endproperty
  a_snap_range: assert property (p_snap_range) else $error("bad snapshot group");

  property p_fault_abort;
    adv && busy && fault_any && !wr |=> st_reg.phase == PH_IDLE && st_reg.error;
  endproperty
  a_fault_abort: assert property (p_fault_abort) else $error("fault did not abort");

  // mode 3 counts as off and does use storage, so only the two loops are named
  property p_no_storage;
    adv && !fault_any && st_reg.phase == PH_BUFIN &&
    (st_reg.tmode == FDIOP_TM_SHORT || st_reg.tmode == FDIOP_TM_LONG)
    |=> st_reg.phase != PH_STOR && !st_reg.stor.valid;
  endproperty
  a_no_storage: assert property (p_no_storage) else $error("storage used in test");

  property p_short_loop;
    s_bufin_short ##0 !st_reg.step_mode && !st_reg.halt_arm |=> s_short_tail;
  endproperty
  a_short_loop: assert property (p_short_loop) else $error("short loop path wrong");

  property p_long_loop;
    adv && !fault_any && st_reg.phase == PH_BUFIN && st_reg.tmode == FDIOP_TM_LONG
    |=> st_reg.phase == PH_DESKEW;
  endproperty
  a_long_loop: assert property (p_long_loop) else $error("long loop skipped deskew");

  property p_halt_sticky;
    st_reg.halted && !ctrl_wr |=> st_reg.halted;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt cleared on its own");
endmodule
`default_nettype wire

//--- dv/fdiop_stor_model.sv
`default_nettype none
module fdiop_stor_model import fdiop_pkg::*; #(
  parameter logic [31:0] RD_WORD = 32'h0000_0000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // request from the block and pacing
  input wire fdiop_stor_req_s req,
  input wire logic slow,
  // answer to the block
  output logic ack,
  output logic [31:0] rdata,
  // bench visibility
  output logic [15:0] count,
  output logic [31:0] last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_reg;
  // ==========================================================
  // storage unit responder
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
      rdata <= 32'h5A5A_A5A5;
      count <= 16'h0;
      last <= 32'h0;
      wait_reg <= 3'h0;
    end else if (req.valid && !ack) begin
      wait_reg <= wait_reg + 3'h1;
      if (wait_reg == (slow ? 3'h6 : 3'h1)) begin
        // one whole 32-bit word per request
        ack <= 1'b1;
        wait_reg <= 3'h0;
        count <= count + 16'h1;
        rdata <= RD_WORD;
        if (req.write) last <= req.data;
      end
    end else if (!req.valid && ack) begin
      ack <= 1'b0;
      // released data must not keep looking valid
      rdata <= ~rdata;
    end
  end
endmodule
`default_nettype wire

//--- dv/fdiop_maint_bench.sv
`default_nettype none
module fdiop_maint_bench import fdiop_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RD_WORD = 32'h6E2D_91B4;
  logic ref_clk, rstn, cyc, stb, we, ack, dev_pin, mem_pin, slow, s_ack;
  logic [15:0] adr, s_cnt;
  logic [3:0] sel;
  logic [31:0] wd, rd, s_rdata, s_last, q, stat;
  fdiop_stor_req_s stor;
  int bad_count, checked, n;
  logic [48:0] rows [11] = '{
    {1'b0, FDIOP_CTRL_OFS, 32'h0}, {1'b0, FDIOP_FAULT_OFS, 32'h0},
    {1'b0, FDIOP_STAT_OFS, 32'h0}, {1'b1, FDIOP_SNSEL_OFS, 32'h5},
    {1'b0, FDIOP_SNSEL_OFS, 32'h5}, {1'b1, FDIOP_SNSEL_OFS, 32'h7},
    {1'b0, FDIOP_SNAP_OFS, 32'h0}, {1'b1, 16'h0040, 32'hFFFF_FFFF},
    {1'b0, 16'h0040, 32'h0}, {1'b1, FDIOP_DATA_OFS, 32'h1234_5678},
    {1'b0, FDIOP_DATA_OFS, 32'h1234_5678}};
  logic [31:0] steps [5] = '{32'h212, 32'h215, 32'h216, 32'h220, 32'h220};
  // snapshot groups 0..6 while halted on entry to buffer-out
  logic [31:0] snaps [7] = '{32'h0000_021D, 32'h0BAD_F00D, 32'h0000_0077, 32'h0000_0077,
    32'h0BAD_F00D, 32'h0000_0000, 32'h0006_0001};

  fdiop_maint dut (.ref_clk(ref_clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wd), .ack_o(ack), .dat_o(rd), .stor_o(stor),
    .stor_ack_i(s_ack), .stor_rdata_i(s_rdata), .dev_fault_i(dev_pin), .mem_fault_i(mem_pin));
  fdiop_stor_model #(.RD_WORD(RD_WORD)) mdl (.ref_clk(ref_clk), .rstn(rstn), .req(stor),
    .slow(slow), .ack(s_ack), .rdata(s_rdata), .count(s_cnt), .last(s_last));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (k >= 40) bad_count++;
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask

  task automatic wait_end();
    int k;
    k = 0;
    stat = 32'h0;
    while (!stat[5] && !stat[6] && k < 40) begin
      bus(1'b0, FDIOP_STAT_OFS, 32'h0);
      stat = q;
      k++;
    end
    if (!stat[FDIOP_ST_DONE] && !stat[FDIOP_ST_ERR]) bad_count++;
  endtask

  task automatic run(input logic d, input logic [31:0] v);
    bus(1'b1, FDIOP_DATA_OFS, v);
    bus(1'b1, FDIOP_CMD_OFS, {31'h0, d});
    wait_end();
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    {cyc, stb, we, dev_pin, mem_pin} = 5'h0;
    adr = 16'h0;
    sel = 4'hF;
    wd = 32'h0;
    slow = 1'b1;
    bad_count = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i][48]) bus(1'b1, rows[i][47:32], rows[i][31:0]);
      else rdc($sformatf("row%0d", i), rows[i][47:32], rows[i][31:0]);
    end
    run(1'b1, 32'hA5C3_0F96);
    chk("stor_wdata", s_last, 32'hA5C3_0F96);
    chk("stor_wr_st", stat[6:4], 3'h2);
    bus(1'b1, FDIOP_STAT_OFS, 32'h60);
    slow <= 1'b0;
    run(1'b0, 32'h0);
    rdc("stor_rdata", FDIOP_DATA_OFS, RD_WORD);
    bus(1'b1, FDIOP_STAT_OFS, 32'h60);
    // short loop first, so a long loop fault points at the deskew path
    for (int m = 1; m < 3; m++) begin
      n = s_cnt;
      bus(1'b1, FDIOP_CTRL_OFS, {25'h0, m[1:0], 5'h0});
      run(1'b1, 32'h3C5A_0000 + m);
      chk("loop_st", {stat[10:9], stat[6:4]}, {m[1:0], 3'h2});
      rdc("loop_data", FDIOP_DATA_OFS, 32'h3C5A_0000 + m);
      chk("loop_stor", {16'h0, s_cnt}, n);
      bus(1'b1, FDIOP_SNSEL_OFS, 32'h3);
      rdc("loop_res", FDIOP_SNAP_OFS, 32'h3C5A_0000 + m);
      bus(1'b1, FDIOP_STAT_OFS, 32'h60);
    end
    bus(1'b1, FDIOP_CTRL_OFS, 32'h30);
    bus(1'b1, FDIOP_DATA_OFS, 32'h77);
    bus(1'b1, FDIOP_CMD_OFS, 32'h1);
    repeat (4) @(posedge ref_clk);
    rdc("step_idle", FDIOP_STAT_OFS, 32'h211);
    foreach (steps[i]) begin
      bus(1'b1, FDIOP_STEP_OFS, 32'h0);
      repeat (2) rdc("step_ph", FDIOP_STAT_OFS, steps[i]);
    end
    bus(1'b1, FDIOP_STAT_OFS, 32'h60);
    // armed at the buffer-out phase of a short loop
    bus(1'b1, FDIOP_CTRL_OFS, 32'h2B);
    bus(1'b1, FDIOP_DATA_OFS, 32'h0BAD_F00D);
    bus(1'b1, FDIOP_CMD_OFS, 32'h1);
    repeat (6) @(posedge ref_clk);
    repeat (3) rdc("halt_st", FDIOP_STAT_OFS, 32'h21D);
    foreach (snaps[i]) begin
      bus(1'b1, FDIOP_SNSEL_OFS, i);
      rdc($sformatf("snap%0d", i), FDIOP_SNAP_OFS, snaps[i]);
    end
    bus(1'b1, FDIOP_CTRL_OFS, 32'h20);
    wait_end();
    chk("halt_rel", {stat[5], stat[3]}, 2'h2);
    rdc("halt_data", FDIOP_DATA_OFS, 32'h0BAD_F00D);
    bus(1'b1, FDIOP_STAT_OFS, 32'h60);
    // injected device, memory, then the same faults on the real pins
    for (int f = 0; f < 4; f++) begin
      if (f < 2) bus(1'b1, FDIOP_FAULT_OFS, 32'h1 << f);
      else {mem_pin, dev_pin} <= 2'(f - 1);
      repeat (4) @(posedge ref_clk);
      bus(1'b1, FDIOP_CMD_OFS, 32'h1);
      wait_end();
      chk("fault_st", {stat[6], stat[4], stat[2:0]}, 5'h10);
      chk("fault_kind", stat[7 + f % 2], 1'b1);
      bus(1'b1, FDIOP_FAULT_OFS, 32'h0);
      {mem_pin, dev_pin} <= 2'h0;
      repeat (4) @(posedge ref_clk);
      bus(1'b1, FDIOP_STAT_OFS, 32'h60);
    end
    // reset while idle, with test mode on and fault flags seen
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("rst_out", {ack, stor.valid}, 2'h0);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rdc("rst_stat", FDIOP_STAT_OFS, 32'h0);
    rdc("rst_ctrl", FDIOP_CTRL_OFS, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
